// File: pwc_wave_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_wave_counter #(
    parameter int CHANNELS = 4,
    parameter int CNT_W = 15
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dec_valid,
    output logic dec_ready,
    input wire logic [15:0] dec_word,
    input wire logic [2:0] dec_sel,
    input wire logic dec_last,
    output logic fetch_req,
    output logic stopped_evt,
    output logic [CHANNELS-1:0] pwm_out
);
    // ***************************************************
    // State
    // ***************************************************
    typedef struct packed {
        pwc_pkg::pwc_state_t st;
        logic mode;
        logic [2:0] presc;
        logic [1:0] load;
        logic [CHANNELS-1:0] idle;
        logic [CNT_W-1:0] top_reg;
        logic [CNT_W-1:0] top;
        logic [CNT_W-1:0] stg_top;
        logic [CHANNELS-1:0][15:0] cmp;
        logic [CHANNELS-1:0][15:0] stg_cmp;
        logic pend;
        logic stop_req;
        logic [6:0] pre;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic [CHANNELS-1:0] pwm;
        logic stopped;
        logic stopped_p;
        logic fetch_p;
        logic [31:0] rdata;
        logic err;
    } pwc_regs_t;

    pwc_regs_t r_ff;
    pwc_regs_t nxt_r;

    logic wr;
    logic rd_setup;
    logic tick;
    logic boundary;
    logic take;
    logic [CNT_W-1:0] cnt_n;
    logic down_n;
    logic [CHANNELS-1:0] wave;

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    // Ratio 2^presc
    assign tick = (r_ff.pre == 7'((8'h01 << r_ff.presc) - 8'h01));
    assign take = dec_valid && dec_ready;

    // ***************************************************
    // Counter step
    // ***************************************************
    always_comb begin
        cnt_n = r_ff.cnt;
        down_n = r_ff.down;
        boundary = 1'b0;
        if (r_ff.st == pwc_pkg::PWC_RUN && tick) begin
            if (!r_ff.mode) begin
                // Runs 0..top-1 so one period is top ticks
                if (r_ff.cnt >= r_ff.top - CNT_W'(1)) begin
                    cnt_n = '0;
                    boundary = 1'b1;
                end else begin
                    cnt_n = r_ff.cnt + CNT_W'(1);
                end
            end else if (!r_ff.down) begin
                if (r_ff.cnt >= r_ff.top) begin
                    cnt_n = r_ff.cnt - CNT_W'(1);
                    down_n = 1'b1;
                end else begin
                    cnt_n = r_ff.cnt + CNT_W'(1);
                end
            end else if (r_ff.cnt <= CNT_W'(1)) begin
                cnt_n = '0;
                down_n = 1'b0;
                boundary = 1'b1;
            end else begin
                cnt_n = r_ff.cnt - CNT_W'(1);
            end
        end
    end

    // ***************************************************
    // Channel compare
    // ***************************************************
    // Level form: with the polarity bit set, high while below compare (low otherwise), so a compare above top
    // never produces an edge and both toggle points fall out for free
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        logic below;
        assign below = ({1'b0, cnt_n} < {1'b0, r_ff.cmp[g][CNT_W-1:0]});
        assign wave[g] = r_ff.cmp[g][pwc_pkg::PWC_WORD_POL_BIT] ? below : !below;
    end

    // ***************************************************
    // Next state
    // ***************************************************
    always_comb begin
        nxt_r = r_ff;
        nxt_r.stopped_p = 1'b0;
        nxt_r.fetch_p = 1'b0;
        nxt_r.cnt = cnt_n;
        nxt_r.down = down_n;
        nxt_r.pre = (r_ff.st == pwc_pkg::PWC_RUN && !tick) ? r_ff.pre + 7'h01 : '0;

        // Register writes
        if (wr && paddr == pwc_pkg::PWC_CTRL_OFS) begin
            nxt_r.mode = pwdata[pwc_pkg::PWC_CTRL_MODE_BIT];
            nxt_r.presc = pwdata[pwc_pkg::PWC_CTRL_PRESC_LSB +: 3];
            nxt_r.load = pwdata[pwc_pkg::PWC_CTRL_LOAD_LSB +: 2];
            nxt_r.idle = pwdata[pwc_pkg::PWC_CTRL_IDLE_LSB +: CHANNELS];
        end
        // Only the shadow is written; the live top moves at sampling points
        if (wr && paddr == pwc_pkg::PWC_TOP_OFS) begin
            nxt_r.top_reg = pwdata[CNT_W-1:0];
        end
        if (wr && paddr == pwc_pkg::PWC_STATUS_OFS && pwdata[pwc_pkg::PWC_ST_STOPPED_BIT]) begin
            nxt_r.stopped = 1'b0;
        end
        if (wr && paddr == pwc_pkg::PWC_TASK_OFS && pwdata[pwc_pkg::PWC_TASK_STOP_BIT]
            && r_ff.st != pwc_pkg::PWC_IDLE) begin
            nxt_r.stop_req = 1'b1;
        end

        // Decoder words: compare values have no register path
        if (take) begin
            if (dec_sel == pwc_pkg::PWC_SEL_TOP) begin
                if (r_ff.load == pwc_pkg::PWC_LOAD_A) begin
                    nxt_r.stg_top = dec_word[CNT_W-1:0];
                end
            end else if (dec_sel < 3'(CHANNELS)) begin
                nxt_r.stg_cmp[dec_sel[1:0]] = dec_word;
            end
            if (dec_last) begin
                nxt_r.pend = 1'b1;
                if (r_ff.load != pwc_pkg::PWC_LOAD_A) begin
                    nxt_r.stg_top = r_ff.top_reg;
                end
            end
        end

        unique case (r_ff.st)
            pwc_pkg::PWC_IDLE: begin
                if (wr && paddr == pwc_pkg::PWC_TASK_OFS && pwdata[pwc_pkg::PWC_TASK_BEGIN_BIT]) begin
                    nxt_r.st = pwc_pkg::PWC_FETCH;
                    nxt_r.fetch_p = 1'b1;
                    nxt_r.pend = 1'b0;
                    if (r_ff.load != pwc_pkg::PWC_LOAD_A) begin
                        nxt_r.stg_top = r_ff.top_reg;
                    end
                end
            end
            pwc_pkg::PWC_FETCH: begin
                if (r_ff.stop_req) begin
                    nxt_r.st = pwc_pkg::PWC_IDLE;
                    nxt_r.stop_req = 1'b0;
                    nxt_r.stopped_p = 1'b1;
                    nxt_r.stopped = 1'b1;
                end else if (r_ff.pend) begin
                    // First set is in; counter starts only now
                    nxt_r.st = pwc_pkg::PWC_RUN;
                    nxt_r.pend = 1'b0;
                    nxt_r.cmp = r_ff.stg_cmp;
                    nxt_r.top = r_ff.stg_top;
                    nxt_r.cnt = '0;
                    nxt_r.down = 1'b0;
                    for (int i = 0; i < CHANNELS; i++) begin
                        nxt_r.pwm[i] = (r_ff.stg_cmp[i][CNT_W-1:0] != '0)
                            ~^ r_ff.stg_cmp[i][pwc_pkg::PWC_WORD_POL_BIT];
                    end
                end
            end
            pwc_pkg::PWC_RUN: begin
                nxt_r.pwm = wave;
                if (boundary) begin
                    if (r_ff.stop_req) begin
                        nxt_r.st = pwc_pkg::PWC_IDLE;
                        nxt_r.stop_req = 1'b0;
                        nxt_r.stopped_p = 1'b1;
                        nxt_r.stopped = 1'b1;
                        nxt_r.cnt = '0;
                        nxt_r.down = 1'b0;
                    end else if (r_ff.pend) begin
                        // New set swapped in only between periods
                        nxt_r.pend = 1'b0;
                        nxt_r.cmp = r_ff.stg_cmp;
                        nxt_r.top = r_ff.stg_top;
                        for (int i = 0; i < CHANNELS; i++) begin
                            nxt_r.pwm[i] = (r_ff.stg_cmp[i][CNT_W-1:0] != '0)
                                ~^ r_ff.stg_cmp[i][pwc_pkg::PWC_WORD_POL_BIT];
                        end
                    end
                end
            end
        endcase
        if (nxt_r.st == pwc_pkg::PWC_IDLE) begin
            nxt_r.pwm = nxt_r.idle;
        end

        // Read data prepared in the setup cycle
        nxt_r.err = 1'b0;
        if (rd_setup) begin
            nxt_r.rdata = '0;
            unique case (paddr)
                pwc_pkg::PWC_CTRL_OFS: begin
                    nxt_r.rdata[pwc_pkg::PWC_CTRL_MODE_BIT] = r_ff.mode;
                    nxt_r.rdata[pwc_pkg::PWC_CTRL_PRESC_LSB +: 3] = r_ff.presc;
                    nxt_r.rdata[pwc_pkg::PWC_CTRL_LOAD_LSB +: 2] = r_ff.load;
                    nxt_r.rdata[pwc_pkg::PWC_CTRL_IDLE_LSB +: CHANNELS] = r_ff.idle;
                end
                pwc_pkg::PWC_TOP_OFS: nxt_r.rdata[CNT_W-1:0] = r_ff.top_reg;
                pwc_pkg::PWC_TASK_OFS: nxt_r.rdata = '0;
                pwc_pkg::PWC_STATUS_OFS: begin
                    nxt_r.rdata[pwc_pkg::PWC_ST_RUN_BIT] = (r_ff.st == pwc_pkg::PWC_RUN);
                    nxt_r.rdata[pwc_pkg::PWC_ST_STOPPED_BIT] = r_ff.stopped;
                    nxt_r.rdata[pwc_pkg::PWC_ST_FETCH_BIT] = (r_ff.st == pwc_pkg::PWC_FETCH);
                    nxt_r.rdata[pwc_pkg::PWC_ST_CNT_LSB +: CNT_W] = r_ff.cnt;
                end
                default: nxt_r.err = 1'b1;
            endcase
        end else if (psel) begin
            nxt_r.err = r_ff.err;
        end
    end

    // ***************************************************
    // Registers
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
            r_ff.st <= pwc_pkg::PWC_IDLE;
            r_ff.top_reg <= pwc_pkg::PWC_TOP_RST;
            r_ff.top <= pwc_pkg::PWC_TOP_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata = r_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && r_ff.err;
    // One set is buffered; the decoder stalls until it is committed
    assign dec_ready = !r_ff.pend && (r_ff.st != pwc_pkg::PWC_IDLE);
    assign fetch_req = r_ff.fetch_p;
    assign stopped_evt = r_ff.stopped_p;
    assign pwm_out = r_ff.pwm;
endmodule : pwc_wave_counter
`default_nettype wire

// File: pwc_pkg.sv
package pwc_pkg;
    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0] PWC_CTRL_OFS = 8'h00;
    localparam logic [7:0] PWC_TOP_OFS = 8'h04;
    localparam logic [7:0] PWC_TASK_OFS = 8'h08;
    localparam logic [7:0] PWC_STATUS_OFS = 8'h0c;
    // CTRL fields
    localparam int PWC_CTRL_MODE_BIT = 0;
    localparam int PWC_CTRL_PRESC_LSB = 1;
    localparam int PWC_CTRL_LOAD_LSB = 4;
    localparam int PWC_CTRL_IDLE_LSB = 6;
    // TASK bits
    localparam int PWC_TASK_BEGIN_BIT = 0;
    localparam int PWC_TASK_STOP_BIT = 1;
    // STATUS bits
    localparam int PWC_ST_RUN_BIT = 0;
    localparam int PWC_ST_STOPPED_BIT = 1;
    localparam int PWC_ST_FETCH_BIT = 2;
    localparam int PWC_ST_CNT_LSB = 16;
    // Compare word layout
    localparam int PWC_WORD_POL_BIT = 15;
    // Reset value, load mode and selector codes
    localparam logic [14:0] PWC_TOP_RST = 15'h03e8;
    localparam logic [1:0] PWC_LOAD_A = 2'h3;
    localparam logic [2:0] PWC_SEL_TOP = 3'h4;
    typedef enum logic [1:0] {PWC_IDLE, PWC_FETCH, PWC_RUN} pwc_state_t;
endpackage : pwc_pkg

// File: pwc_wave_counter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ******************
// Port checks
// ******************
module pwc_wave_counter_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dec_valid,
    input wire logic dec_ready,
    input wire logic dec_last,
    input wire logic fetch_req,
    input wire logic stopped_evt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire took_last = dec_valid && dec_ready && dec_last;
    a_ready_const: assert property (pready)
        else $error("pready not high");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read returns data");
    a_fetch_pulse: assert property (fetch_req |=> !fetch_req)
        else $error("fetch request longer than one cycle");
    a_fetch_ready: assert property (fetch_req |-> dec_ready)
        else $error("fetch started without decoder ready");
    a_set_pending: assert property (took_last |=> !dec_ready)
        else $error("decoder ready after last word of set");
    a_stop_pulse: assert property (stopped_evt |=> !stopped_evt)
        else $error("stopped event longer than one cycle");
    a_stop_idle: assert property (stopped_evt |-> !dec_ready && !fetch_req)
        else $error("not idle at stopped event");
    c_fetch: cover property (fetch_req);
    c_last: cover property (took_last);
    c_stop: cover property (stopped_evt);
endmodule : pwc_wave_counter_chk
bind pwc_wave_counter pwc_wave_counter_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dec_valid(dec_valid), .dec_ready(dec_ready),
    .dec_last(dec_last), .fetch_req(fetch_req), .stopped_evt(stopped_evt));
`default_nettype wire

// File: pwc_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// ******************
// Pin loads
// ******************
module pwc_pin_load (
    input wire logic pclk,
    input wire logic meas,
    input wire logic [3:0] pins,
    output logic [63:0] hi_cnt_ff
);
    // Loads only watch; counting restarts whenever meas drops
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (!meas) begin
                hi_cnt_ff[16*i+:16] <= 16'h0;
            end else begin
                hi_cnt_ff[16*i+:16] <= hi_cnt_ff[16*i+:16] + 16'(pins[i]);
            end
        end
    end
endmodule : pwc_pin_load
`default_nettype wire

// File: tb_pwm_wave_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ******************
// Bench
// ******************
module tb_pwm_wave_counter;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic dec_valid = 1'b0;
    logic [15:0] dec_word = 16'h0;
    logic [2:0] dec_sel = 3'h0;
    logic dec_last = 1'b0;
    logic meas = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, dec_ready, fetch_req, stopped_evt, er;
    logic [3:0] pwm_out;
    logic [63:0] hi;
    logic [31:0] rd;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 pclk = ~pclk;
    pwc_wave_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec_valid(dec_valid),
        .dec_ready(dec_ready), .dec_word(dec_word), .dec_sel(dec_sel),
        .dec_last(dec_last), .fetch_req(fetch_req), .stopped_evt(stopped_evt),
        .pwm_out(pwm_out));
    pwc_pin_load i_load (.pclk(pclk), .meas(meas), .pins(pwm_out), .hi_cnt_ff(hi));
    task automatic print_verdict();
        $display("Mismatches %0d in %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    // Leaves one idle cycle first so back-to-back calls never retouch psel
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the same rising edge that samples pready high
        do begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            er = pslverr;
        end while (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic word(input logic [2:0] s, input logic [15:0] w, input logic l);
        logic ok;
        @(posedge pclk);
        dec_valid <= 1'b1;
        dec_sel <= s;
        dec_word <= w;
        dec_last <= l;
        // Word counts as taken at the rising edge that sees dec_ready high
        do begin
            @(posedge pclk);
            ok = dec_ready;
        end while (ok !== 1'b1);
        dec_valid <= 1'b0;
        dec_word <= ~w;
    endtask : word
    task automatic start(input logic [31:0] c, input logic [31:0] t);
        apb(1'b1, pwc_pkg::PWC_CTRL_OFS, c);
        apb(1'b1, pwc_pkg::PWC_TOP_OFS, t);
        apb(1'b1, pwc_pkg::PWC_TASK_OFS, 32'h1);
    endtask : start
    task automatic measure(input int n);
        repeat (4) @(posedge pclk);
        meas <= 1'b1;
        repeat (n) @(posedge pclk);
        meas <= 1'b0;
        @(negedge pclk);
    endtask : measure
    task automatic halt(input logic [3:0] idl);
        int k;
        apb(1'b1, pwc_pkg::PWC_TASK_OFS, 32'h2);
        for (k = 0; k < 200 && stopped_evt !== 1'b1; k++) @(negedge pclk);
        chk(32'(k < 200), 32'h1);
        repeat (2) @(negedge pclk);
        chk(32'(pwm_out), 32'(idl));
        apb(1'b0, pwc_pkg::PWC_STATUS_OFS, 32'h0);
        chk(32'(rd[1]), 32'h1);
        chk(32'(rd[0]), 32'h0);
        // Sticky flag cleared so the next stop has to set it again
        apb(1'b1, pwc_pkg::PWC_STATUS_OFS, 32'h2);
        apb(1'b0, pwc_pkg::PWC_STATUS_OFS, 32'h0);
        chk(32'(rd[1]), 32'h0);
    endtask : halt
    task automatic t_regs();
        apb(1'b0, pwc_pkg::PWC_TOP_OFS, 32'h0);
        chk(rd, 32'h3e8);
        apb(1'b1, pwc_pkg::PWC_TOP_OFS, 32'h7fff);
        apb(1'b0, pwc_pkg::PWC_TOP_OFS, 32'h0);
        chk(rd, 32'h7fff);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(er), 32'h1);
    endtask : t_regs
    task automatic t_up();
        start(32'h0, 32'd10);
        word(3'd0, 16'h8004, 1'b0);
        word(3'd1, 16'h0004, 1'b0);
        word(3'd2, 16'h8000, 1'b0);
        word(3'd3, 16'h800a, 1'b1);
        // Mid-run top write must wait for the last word of the next set
        apb(1'b1, pwc_pkg::PWC_TOP_OFS, 32'd3);
        measure(20);
        chk(32'(hi[15:0]), 32'd8);
        chk(32'(hi[31:16]), 32'd12);
        chk(32'(hi[47:32]), 32'd0);
        chk(32'(hi[63:48]), 32'd20);
        // New set during playback resamples the top register
        word(3'd0, 16'h8001, 1'b0);
        word(3'd1, 16'h0001, 1'b0);
        word(3'd2, 16'h8000, 1'b0);
        word(3'd3, 16'h8003, 1'b1);
        repeat (12) @(posedge pclk);
        measure(12);
        chk(32'(hi[15:0]), 32'd4);
        chk(32'(hi[31:16]), 32'd8);
        chk(32'(hi[63:48]), 32'd12);
        halt(4'h0);
    endtask : t_up
    task automatic t_updown();
        start(32'h143, 32'd5);
        word(3'd0, 16'h8002, 1'b0);
        word(3'd1, 16'h8007, 1'b0);
        word(3'd2, 16'h0002, 1'b0);
        word(3'd3, 16'h0000, 1'b1);
        measure(40);
        chk(32'(hi[15:0]), 32'd12);
        chk(32'(hi[31:16]), 32'd40);
        chk(32'(hi[47:32]), 32'd28);
        chk(32'(hi[63:48]), 32'd40);
        halt(4'h5);
    endtask : t_updown
    task automatic t_wave();
        start(32'h30, 32'd20);
        word(3'd0, 16'h8003, 1'b0);
        word(3'd4, 16'h0008, 1'b1);
        measure(16);
        chk(32'(hi[15:0]), 32'd6);
        halt(4'h0);
        // Stop while still fetching ends at once
        apb(1'b1, pwc_pkg::PWC_TASK_OFS, 32'h1);
        halt(4'h0);
    endtask : t_wave
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_up();
        t_updown();
        t_wave();
        print_verdict();
    end
endmodule : tb_pwm_wave_counter
`default_nettype wire
